/* File: dv/test_timer8_counter_compare_unit.sv */
// self-checking bench for the 8-bit timer with compare units
`timescale 1ns/100ps
`default_nettype none
`include "timer8_map.vh"
module test_timer8_counter_compare_unit;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic        extCountPin = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, compareOutA, compareOutB;
  wire         overflowIrq, matchIrqA, matchIrqB;
  logic [31:0] rdat;
  logic        rerr;
  int          n_errors = 0;
  int          compares = 0;
  timer8_counter_compare_unit uut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .extCountPin, .compareOutA,
    .compareOutB, .overflowIrq, .matchIrqA, .matchIrqB);
  // 40 mhz clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic stop_test();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one apb transfer; idle edge after it so psel is never set twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      stop_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // tick from the system clock for n cycles, then stop
  task automatic run(input int n);
    wr(`T8_OFF_CTRL_SECOND, 32'h1);
    cyc(n);
    wr(`T8_OFF_CTRL_SECOND, 32'h0);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rd(12'(i * 4));
      chk("reset reg", 32'h0, rdat);
    end
    chk("reset outs", 32'h0, {compareOutA, compareOutB, overflowIrq, matchIrqA, matchIrqB});
    rd(12'h020);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    $display("t_reset done");
  endtask
  task automatic t_stop();
    wr(`T8_OFF_COUNT, 32'h5A);
    cyc(20);
    rd(`T8_OFF_COUNT);
    chk("stopped count", 32'h5A, rdat);
    // write with lane 0 off must be ignored
    pstrb <= 4'h0;
    wr(`T8_OFF_COUNT, 32'hA5);
    pstrb <= 4'hF;
    rd(`T8_OFF_COUNT);
    chk("lane off write", 32'h5A, rdat);
    wr(`T8_OFF_CTRL_SECOND, 32'h1);
    wr(`T8_OFF_COUNT, 32'h33);
    wr(`T8_OFF_CTRL_SECOND, 32'h0);
    rd(`T8_OFF_COUNT);
    chk("write while counting", 32'h1, {31'h0, rdat - 32'h33 < 32'h8});
    $display("t_stop done");
  endtask
  task automatic t_wrap();
    wr(`T8_OFF_COUNT, 32'hFE);
    run(10);
    rd(`T8_OFF_COUNT);
    chk("wrapped count", 32'h1, {31'h0, rdat < 32'h10 && rdat > 32'h0});
    rd(`T8_OFF_FLAG);
    chk("overflow flag", 32'h1, rdat & 32'h1);
    wr(`T8_OFF_MASK, 32'h1);
    cyc(3);
    chk("overflow irq", 32'h1, {31'h0, overflowIrq});
    wr(`T8_OFF_SERVICE, 32'h7);
    cyc(3);
    chk("serviced irq", 32'h0, {31'h0, overflowIrq});
    wr(`T8_OFF_MASK, 32'h0);
    $display("t_wrap done");
  endtask
  task automatic t_match();
    wr(`T8_OFF_CMP_A, 32'h30);
    wr(`T8_OFF_COUNT, 32'h20);
    wr(`T8_OFF_FLAG, 32'h7);
    run(30);
    rd(`T8_OFF_FLAG);
    chk("match a flag", 32'h2, rdat & 32'h2);
    wr(`T8_OFF_MASK, 32'h2);
    cyc(3);
    chk("match a irq", 32'h1, {31'h0, matchIrqA});
    wr(`T8_OFF_FLAG, 32'h2);
    cyc(3);
    chk("cleared a irq", 32'h0, {31'h0, matchIrqA});
    wr(`T8_OFF_CMP_B, 32'h45);
    wr(`T8_OFF_COUNT, 32'h45);
    wr(`T8_OFF_FLAG, 32'h7);
    run(6);
    rd(`T8_OFF_FLAG);
    chk("blocked match b", 32'h0, rdat & 32'h4);
    $display("t_match done");
  endtask
  task automatic t_pin();
    for (int cs = 6; cs < 8; cs++) begin
      wr(`T8_OFF_COUNT, 32'h0);
      wr(`T8_OFF_CTRL_SECOND, 32'(cs));
      repeat (5) begin
        extCountPin <= 1'b1;
        cyc(4);
        extCountPin <= 1'b0;
        cyc(4);
      end
      cyc(8);
      wr(`T8_OFF_CTRL_SECOND, 32'h0);
      rd(`T8_OFF_COUNT);
      chk("pin ticks", 32'h5, rdat);
    end
    $display("t_pin done");
  endtask
  // force with a given output mode setting
  task automatic frc(input logic [31:0] first, input logic [31:0] strobe);
    wr(`T8_OFF_CTRL_FIRST, first);
    wr(`T8_OFF_CTRL_SECOND, strobe);
    cyc(3);
  endtask
  task automatic t_force();
    wr(`T8_OFF_FLAG, 32'h7);
    frc(32'h40, 32'h80);
    chk("force toggle a", 32'h1, {31'h0, compareOutA});
    rd(`T8_OFF_CTRL_SECOND);
    chk("force reads zero", 32'h0, rdat);
    rd(`T8_OFF_FLAG);
    chk("force no flag", 32'h0, rdat);
    frc(32'h00, 32'h80);
    chk("mode zero no action", 32'h1, {31'h0, compareOutA});
    frc(32'h80, 32'h80);
    chk("force clear a", 32'h0, {31'h0, compareOutA});
    frc(32'h30, 32'h40);
    chk("force set b", 32'h1, {31'h0, compareOutB});
    frc(32'h33, 32'h00);
    chk("state kept", 32'h1, {31'h0, compareOutB});
    $display("t_force done");
  endtask
  task automatic t_buffer();
    frc(32'h00, 32'h00);
    wr(`T8_OFF_CMP_B, 32'h60);
    wr(`T8_OFF_CTRL_FIRST, 32'h03);
    wr(`T8_OFF_CMP_B, 32'h90);
    rd(`T8_OFF_CMP_B);
    chk("buffer readback", 32'h90, rdat);
    wr(`T8_OFF_COUNT, 32'h58);
    wr(`T8_OFF_FLAG, 32'h7);
    run(12);
    rd(`T8_OFF_FLAG);
    chk("old compare active", 32'h4, rdat & 32'h4);
    wr(`T8_OFF_MASK, 32'h4);
    cyc(3);
    chk("match b irq", 32'h1, {31'h0, matchIrqB});
    wr(`T8_OFF_MASK, 32'h0);
    $display("t_buffer done");
  endtask
  // clear on match with compare a as top
  task automatic t_ctc();
    wr(`T8_OFF_CTRL_FIRST, 32'h02);
    wr(`T8_OFF_CMP_A, 32'h05);
    wr(`T8_OFF_COUNT, 32'h0);
    run(40);
    rd(`T8_OFF_COUNT);
    chk("ctc top", 32'h1, {31'h0, rdat <= 32'h5});
    $display("t_ctc done");
  endtask
  // duty of output b in modes 5 and 7, top 9, compare 4
  task automatic t_pwm();
    int hi;
    int per;
    for (int m = 5; m < 8; m += 2) begin
      // fast: 4 high of 10; dual slope: 8 high of 18; two periods each
      per = (m == 7) ? 20 : 36;
      wr(`T8_OFF_CTRL_SECOND, 32'h0);
      wr(`T8_OFF_CTRL_FIRST, 32'h0);
      wr(`T8_OFF_CMP_A, 32'h9);
      wr(`T8_OFF_CMP_B, 32'h4);
      wr(`T8_OFF_COUNT, 32'h0);
      wr(`T8_OFF_CTRL_FIRST, 32'h20 | 32'(m & 3));
      wr(`T8_OFF_CTRL_SECOND, 32'h9);
      cyc(40);
      hi = 0;
      repeat (per) begin
        @(posedge clk_sys);
        if (compareOutB === 1'b1) begin
          hi++;
        end
      end
      chk("pwm high cycles", (m == 7) ? 32'h8 : 32'h10, 32'(hi));
      wr(`T8_OFF_CTRL_SECOND, 32'h0);
      rd(`T8_OFF_COUNT);
      chk("pwm below top", 32'h1, {31'h0, rdat <= 32'h9});
    end
    $display("t_pwm done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    cyc(6);
    rst <= 1'b0;
    cyc(1);
    t_reset();
    t_stop();
    t_wrap();
    t_match();
    t_pin();
    t_force();
    t_buffer();
    t_ctc();
    t_pwm();
    stop_test();
  end
endmodule
`default_nettype wire

/* File: dv/timer8_checker.sv */
// port-level assertions for the 8-bit timer apb slave
`timescale 1ns/100ps
`default_nettype none
`include "timer8_map.vh"
module timer8_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        overflowIrq,
  input wire logic        matchIrqA,
  input wire logic        matchIrqB
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // access cycles as seen by the slave
  wire rdAcc = pready && !pwrite;
  wire wrAcc = psel && penable && pready && pwrite && pstrb[0];
  // zero wait states, one pulse per transfer
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside one access cycle");
  a_err_unmapped: assert property (pready && paddr > `T8_OFF_SERVICE |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (pready && paddr <= `T8_OFF_SERVICE && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("error on mapped address");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_upper_zero: assert property (rdAcc |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_force_zero: assert property (rdAcc && paddr == `T8_OFF_CTRL_SECOND |->
    prdata[7:6] == 2'h0) else $error("force bits read back set");
  a_service_zero: assert property (rdAcc && paddr == `T8_OFF_SERVICE |-> prdata == 32'h0)
    else $error("service port reads nonzero");
  a_mask_gates: assert property (wrAcc && paddr == `T8_OFF_MASK && pwdata[2:0] == 3'h0
    |=> ##1 !overflowIrq && !matchIrqA && !matchIrqB) else $error("request not masked");
endmodule
bind timer8_counter_compare_unit timer8_checker chk (.clk_sys, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .overflowIrq,
  .matchIrqA, .matchIrqB);
`default_nettype wire

/* File: rtl/timer8_counter_compare_unit.v */
// 8-bit timer/counter with two compare units behind an APB slave
`timescale 1ns/100ps
`default_nettype none
`include "timer8_map.vh"

// Notes on behaviour
// - counter and compare registers are 8 bits
// - three request flags, each masked separately
// - tick from prescaler or pin, edge chosen
// - tick source zero stops counter
// - counter readable and writable any time
// - counter write beats count or clear
// - each tick clears, increments or decrements
// - mode field split across both controls
// - bottom at 0x00, max at 0xFF
// - top is 0xFF or compare A
// - match sets flag on next tick
// - flag cleared by service or writing one
// - overflow flag set per mode
// - compare buffered only in PWM modes
// - buffer loads only at top, in fast and phase-correct modes
// - software reaches buffer or active register
// - outputs formed from match, mode, direction, bottom
// - force updates output in non-PWM modes only, no flag or clear
// - counter write blocks next tick's match
// - output state kept across mode changes
// - output mode bits act at once
// - output states reset to zero
// - output mode zero leaves state alone
// - modes 0 normal, 2 ctc, 3/7 fast
module timer8_counter_compare_unit (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        extCountPin,
  output reg         compareOutA,
  output reg         compareOutB,
  output reg         overflowIrq,
  output reg         matchIrqA,
  output reg         matchIrqB
);

  reg  [7:0] timerCtrlFirst_reg;
  reg  [7:0] timerCtrlSecond_reg;
  reg  [7:0] countValue_reg;
  reg  [7:0] cmpActiveA_reg;
  reg  [7:0] cmpActiveB_reg;
  reg  [7:0] cmpBufA_reg;
  reg  [7:0] cmpBufB_reg;
  reg  [2:0] irqMask_reg;
  reg  [2:0] flag_reg;
  reg        outStateA_reg;
  reg        outStateB_reg;
  reg        countDown_reg;
  reg        blockMatch_reg;
  reg  [9:0] prescale_reg;
  reg        extSync1_reg;
  reg        extSync2_reg;
  reg        extPrev_reg;

  wire       busWrite  = psel & penable & pwrite;
  wire       laneLow   = pstrb[0];
  wire [2:0] tickSel   = timerCtrlSecond_reg[`T8_CS_HI:`T8_CS_LO];
  wire [1:0] comA      = timerCtrlFirst_reg[`T8_COMA_HI:`T8_COMA_LO];
  wire [1:0] comB      = timerCtrlFirst_reg[`T8_COMB_HI:`T8_COMB_LO];
  wire       hitAddr   = (paddr == `T8_OFF_CTRL_FIRST) | (paddr == `T8_OFF_CTRL_SECOND) |
                         (paddr == `T8_OFF_COUNT) | (paddr == `T8_OFF_CMP_A) |
                         (paddr == `T8_OFF_CMP_B) | (paddr == `T8_OFF_MASK) |
                         (paddr == `T8_OFF_FLAG) | (paddr == `T8_OFF_SERVICE);
  wire       wrOk      = busWrite & laneLow & hitAddr;
  wire       wrCount   = wrOk & (paddr == `T8_OFF_COUNT);

  // mode field gathered from both control registers
  wire [2:0] waveMode  = {timerCtrlSecond_reg[`T8_WGM_HI],
                          timerCtrlFirst_reg[`T8_WGM_LO_HI:`T8_WGM_LO_LO]};
  wire       modeCtc   = (waveMode == `T8_WGM_CTC);
  wire       modeFast  = (waveMode == `T8_WGM_FAST_FF) | (waveMode == `T8_WGM_FAST_A);
  wire       modePc    = (waveMode == `T8_WGM_PCPWM_FF) | (waveMode == `T8_WGM_PCPWM_A);
  wire       modePwm   = modeFast | modePc;
  // top is fixed max or compare A
  wire       topIsA    = (waveMode == `T8_WGM_FAST_A) | (waveMode == `T8_WGM_PCPWM_A) | modeCtc;
  wire [7:0] topValue  = topIsA ? cmpActiveA_reg : `T8_MAX;
  wire       atBottom  = (countValue_reg == `T8_BOTTOM);
  wire       atMax     = (countValue_reg == `T8_MAX);
  wire       atTop     = (countValue_reg == topValue);
  wire       eqA       = (countValue_reg == cmpActiveA_reg);
  wire       eqB       = (countValue_reg == cmpActiveB_reg);

  // two-stage sync of the count pin before any edge logic
  always @(posedge clk_sys) begin
    if (rst) begin
      extSync1_reg <= 1'b0;
      extSync2_reg <= 1'b0;
      extPrev_reg  <= 1'b0;
    end else begin
      extSync1_reg <= extCountPin;
      extSync2_reg <= extSync1_reg;
      extPrev_reg  <= extSync2_reg;
    end
  end

  // free-running prescaler; never reset by software, so first period may be short
  always @(posedge clk_sys) begin
    if (rst) begin
      prescale_reg <= 10'h000;
    end else begin
      prescale_reg <= prescale_reg + 10'h001;
    end
  end

  reg timerTick;
  always @* begin
    case (tickSel)
      `T8_CS_DIV1:     timerTick = 1'b1;
      `T8_CS_DIV8:     timerTick = (prescale_reg[2:0] == 3'h7);
      `T8_CS_DIV64:    timerTick = (prescale_reg[5:0] == 6'h3F);
      `T8_CS_DIV256:   timerTick = (prescale_reg[7:0] == 8'hFF);
      `T8_CS_DIV1024:  timerTick = (prescale_reg == 10'h3FF);
      `T8_CS_EXT_FALL: timerTick = extPrev_reg & ~extSync2_reg;
      `T8_CS_EXT_RISE: timerTick = ~extPrev_reg & extSync2_reg;
      default:         timerTick = 1'b0;
    endcase
  end

  // matches suppressed on the tick after a counter write
  wire matchA = eqA & timerTick & ~blockMatch_reg;
  wire matchB = eqB & timerTick & ~blockMatch_reg;

  always @(posedge clk_sys) begin
    if (rst) begin
      blockMatch_reg <= 1'b0;
    end else if (wrCount) begin
      blockMatch_reg <= 1'b1;
    end else if (timerTick) begin
      blockMatch_reg <= 1'b0;
    end
  end

  // next count per mode; phase-correct turns at top and bottom
  reg [7:0] countNext;
  reg       downNext;
  reg       ovfEvent;
  always @* begin
    countNext = countValue_reg;
    downNext  = countDown_reg;
    ovfEvent  = 1'b0;
    if (modePc) begin
      if (atTop) begin
        downNext = 1'b1;
      end else if (atBottom) begin
        downNext = 1'b0;
      end
      countNext = (atTop | (countDown_reg & ~atBottom)) ? countValue_reg - 8'h01
                                                       : countValue_reg + 8'h01;
      ovfEvent  = atBottom;
    end else if ((modeCtc | modeFast) & atTop) begin
      countNext = `T8_BOTTOM;
      ovfEvent  = modeFast | atMax;
    end else begin
      countNext = countValue_reg + 8'h01;
      ovfEvent  = atMax;
    end
  end

  // counter access is free at all times
  // software write overrides count and clear
  always @(posedge clk_sys) begin
    if (rst) begin
      countValue_reg <= `T8_RESET_BYTE;
      countDown_reg  <= 1'b0;
    end else if (wrCount) begin
      countValue_reg <= pwdata[7:0];
    end else if (timerTick) begin
      countValue_reg <= countNext;
      countDown_reg  <= downNext;
    end
  end

  // buffer load at top (fast) or at top (phase-correct)
  wire loadActive = timerTick & atTop & modePwm;
  // software writes land in buffer or active register
  always @(posedge clk_sys) begin
    if (rst) begin
      cmpBufA_reg    <= `T8_RESET_BYTE;
      cmpBufB_reg    <= `T8_RESET_BYTE;
      cmpActiveA_reg <= `T8_RESET_BYTE;
      cmpActiveB_reg <= `T8_RESET_BYTE;
    end else begin
      if (wrOk & (paddr == `T8_OFF_CMP_A)) begin
        cmpBufA_reg <= pwdata[7:0];
      end
      if (wrOk & (paddr == `T8_OFF_CMP_B)) begin
        cmpBufB_reg <= pwdata[7:0];
      end
      if (!modePwm) begin
        cmpActiveA_reg <= (wrOk & (paddr == `T8_OFF_CMP_A)) ? pwdata[7:0] : cmpActiveA_reg;
        cmpActiveB_reg <= (wrOk & (paddr == `T8_OFF_CMP_B)) ? pwdata[7:0] : cmpActiveB_reg;
      end else if (loadActive) begin
        cmpActiveA_reg <= cmpBufA_reg;
        cmpActiveB_reg <= cmpBufB_reg;
      end
    end
  end

  // force strobes act only in non-PWM modes
  // strobes live for the write cycle only
  wire forceA = wrOk & (paddr == `T8_OFF_CTRL_SECOND) & pwdata[`T8_FORCE_A] & ~modePwm;
  wire forceB = wrOk & (paddr == `T8_OFF_CTRL_SECOND) & pwdata[`T8_FORCE_B] & ~modePwm;

  // output state update; mode bits read live, never buffered
  function outNext;
    input       cur;
    input [1:0] com;
    input       hit;
    input       pwm;
    input       pc;
    input       down;
    input       bottom;
    begin
      outNext = cur;
      if (com != 2'h0) begin
        if (!pwm) begin
          if (hit) begin
            outNext = (com == 2'h1) ? ~cur : com[0];
          end
        end else if (com[1]) begin
          if (pc) begin
            if (hit) begin
              outNext = com[0] ^ down;
            end
          end else if (hit) begin
            outNext = com[0];
          end else if (bottom) begin
            outNext = ~com[0];
          end
        end
      end
    end
  endfunction

  // mode zero leaves state as is
  always @(posedge clk_sys) begin
    if (rst) begin
      outStateA_reg <= 1'b0;
      outStateB_reg <= 1'b0;
    end else begin
      outStateA_reg <= outNext(outStateA_reg, comA, matchA | forceA, modePwm, modePc,
                               countDown_reg, timerTick & atBottom & ~modePc);
      outStateB_reg <= outNext(outStateB_reg, comB, matchB | forceB, modePwm, modePc,
                               countDown_reg, timerTick & atBottom & ~modePc);
    end
  end

  // flags set by events, masked onto request outputs
  // match flag set on the tick
  // cleared by service pulse or one written; set wins
  // overflow set at max; at top in fast, at bottom in phase-correct
  wire [2:0] flagSet = {matchB, matchA, timerTick & ovfEvent & ~wrCount};
  wire [2:0] flagClr = (wrOk & (paddr == `T8_OFF_FLAG))    ? pwdata[2:0] :
                       (wrOk & (paddr == `T8_OFF_SERVICE)) ? pwdata[2:0] : 3'h0;
  always @(posedge clk_sys) begin
    if (rst) begin
      flag_reg <= 3'h0;
    end else begin
      flag_reg <= flagSet | (flag_reg & ~flagClr);
    end
  end

  // control and mask registers; force bits never stored
  always @(posedge clk_sys) begin
    if (rst) begin
      timerCtrlFirst_reg  <= `T8_RESET_BYTE;
      timerCtrlSecond_reg <= `T8_RESET_BYTE;
      irqMask_reg         <= 3'h0;
    end else if (wrOk) begin
      if (paddr == `T8_OFF_CTRL_FIRST) begin
        timerCtrlFirst_reg <= pwdata[7:0] & 8'hF3;
      end
      if (paddr == `T8_OFF_CTRL_SECOND) begin
        timerCtrlSecond_reg <= pwdata[7:0] & 8'h0F;
      end
      if (paddr == `T8_OFF_MASK) begin
        irqMask_reg <= pwdata[2:0];
      end
    end
  end

  // APB read data; compare read returns whichever register software owns
  reg [7:0] readByte;
  always @* begin
    case (paddr)
      `T8_OFF_CTRL_FIRST:  readByte = timerCtrlFirst_reg;
      `T8_OFF_CTRL_SECOND: readByte = timerCtrlSecond_reg;
      `T8_OFF_COUNT:       readByte = countValue_reg;
      `T8_OFF_CMP_A:       readByte = modePwm ? cmpBufA_reg : cmpActiveA_reg;
      `T8_OFF_CMP_B:       readByte = modePwm ? cmpBufB_reg : cmpActiveB_reg;
      `T8_OFF_MASK:        readByte = {5'h00, irqMask_reg};
      `T8_OFF_FLAG:        readByte = {5'h00, flag_reg};
      default:             readByte = 8'h00;
    endcase
  end

  // zero-wait slave: ready pulses in the access cycle via a registered setup
  always @(posedge clk_sys) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hitAddr;
      prdata  <= (psel & ~penable & ~pwrite) ? {24'h000000, readByte} : 32'h00000000;
    end
  end

  // registered outputs
  always @(posedge clk_sys) begin
    if (rst) begin
      compareOutA <= 1'b0;
      compareOutB <= 1'b0;
      overflowIrq <= 1'b0;
      matchIrqA   <= 1'b0;
      matchIrqB   <= 1'b0;
    end else begin
      compareOutA <= outStateA_reg;
      compareOutB <= outStateB_reg;
      overflowIrq <= flag_reg[`T8_BIT_OVF] & irqMask_reg[`T8_BIT_OVF];
      matchIrqA   <= flag_reg[`T8_BIT_MATCH_A] & irqMask_reg[`T8_BIT_MATCH_A];
      matchIrqB   <= flag_reg[`T8_BIT_MATCH_B] & irqMask_reg[`T8_BIT_MATCH_B];
    end
  end

endmodule
`default_nettype wire

/* File: rtl/timer8_map.vh */
// register offsets, field positions, mode and tick source codes and reset values for the 8-bit timer
`ifndef TIMER8_MAP_VH
`define TIMER8_MAP_VH

// register byte offsets
`define T8_OFF_CTRL_FIRST   12'h000
`define T8_OFF_CTRL_SECOND  12'h004
`define T8_OFF_COUNT        12'h008
`define T8_OFF_CMP_A        12'h00C
`define T8_OFF_CMP_B        12'h010
`define T8_OFF_MASK         12'h014
`define T8_OFF_FLAG         12'h018
`define T8_OFF_SERVICE      12'h01C

// first control: [7:6] out mode a, [5:4] out mode b, [1:0] mode low bits
`define T8_COMA_HI          7
`define T8_COMA_LO          6
`define T8_COMB_HI          5
`define T8_COMB_LO          4
`define T8_WGM_LO_HI        1
`define T8_WGM_LO_LO        0
// second control: [7] force a, [6] force b, [3] mode bit 2, [2:0] tick source
`define T8_FORCE_A          7
`define T8_FORCE_B          6
`define T8_WGM_HI           3
`define T8_CS_HI            2
`define T8_CS_LO            0
// flag and mask bits
`define T8_BIT_OVF          0
`define T8_BIT_MATCH_A      1
`define T8_BIT_MATCH_B      2

// waveform modes
`define T8_WGM_NORMAL       3'h0
`define T8_WGM_PCPWM_FF     3'h1
`define T8_WGM_CTC          3'h2
`define T8_WGM_FAST_FF      3'h3
`define T8_WGM_PCPWM_A      3'h5
`define T8_WGM_FAST_A       3'h7

// tick sources
`define T8_CS_STOP          3'h0
`define T8_CS_DIV1          3'h1
`define T8_CS_DIV8          3'h2
`define T8_CS_DIV64         3'h3
`define T8_CS_DIV256        3'h4
`define T8_CS_DIV1024       3'h5
`define T8_CS_EXT_FALL      3'h6
`define T8_CS_EXT_RISE      3'h7

// values and reset
`define T8_BOTTOM           8'h00
`define T8_MAX              8'hFF
`define T8_RESET_BYTE       8'h00
`endif
